/* rtl/lcdcs_pkg.sv */
// lcdcs_pkg: constants, types and register map of the lcd common/segment drive block
package lcdcs_pkg;

  // avalon-mm register bus widths
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_MODE    = 10'h000; // panel_mode_reg
  localparam logic [ADDR_W-1:0] OFS_PAT_A   = 10'h004; // key_pattern_reg_a
  localparam logic [ADDR_W-1:0] OFS_PAT_B   = 10'h008; // key_pattern_reg_b
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 10'h00c; // scan position, read only
  localparam logic [ADDR_W-1:0] OFS_DISP    = 10'h100; // display memory, one byte per word

  // panel_mode_reg field positions
  localparam int unsigned MODE_KEY_SCAN_BIT = 0;  // key_scan_enable
  localparam int unsigned MODE_SLICE_LSB    = 1;  // slice count code, 3 bits
  localparam int unsigned MODE_BIAS_LSB     = 4;  // bias method code, 2 bits
  localparam int unsigned MODE_DISP_ON_BIT  = 7;  // display output enable
  localparam logic [7:0]  MODE_RESET        = 8'h00;

  // status register field positions
  localparam int unsigned STAT_SLICE_LSB = 0;     // active backplane index, 3 bits
  localparam int unsigned STAT_KEY_BIT   = 3;     // key-scan slice running
  localparam int unsigned STAT_PHASE_BIT = 4;     // current frame half

  // display memory bytes whose upper nibble is not storage
  localparam int unsigned NIBBLE_ONLY_BYTES = 4;

  // timing: one frame half lasts 10 us by default
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned HALF_TIME_NS = 10000;
  localparam int unsigned HALF_CYCLES  = (HALF_TIME_NS * CLK_MHZ) / 1000;

  // number of backplane lines
  localparam int unsigned N_BP = 8;

  // slice count selection
  typedef enum logic [2:0] {
    SLICE_STATIC = 3'h0,
    SLICE_TWO    = 3'h1,
    SLICE_THREE  = 3'h2,
    SLICE_FOUR   = 3'h3,
    SLICE_EIGHT  = 3'h4
  } lcdcs_slice_t;

  // bias method selection
  typedef enum logic [1:0] {
    BIAS_STATIC  = 2'h0,
    BIAS_HALF    = 2'h1,
    BIAS_THIRD   = 2'h2,
    BIAS_QUARTER = 2'h3
  } lcdcs_bias_t;

  // bias tap selection driven to each line's analog switch
  typedef enum logic [2:0] {
    TAP_GND   = 3'h0,
    TAP_ONE   = 3'h1, // bias_tap_one
    TAP_TWO   = 3'h2, // bias_tap_two
    TAP_THREE = 3'h3, // bias_tap_three
    TAP_TOP   = 3'h4  // bias_tap_top
  } lcdcs_tap_t;

  // avalon-mm request carried as one bundle
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } lcdcs_avl_req_t;

endpackage : lcdcs_pkg

/* rtl/lcdcs_tap_sel.sv */
// lcdcs_tap_sel: bias tap chosen for one line from bias method, frame half and select
`timescale 1ns/1ps
`default_nettype none
module lcdcs_tap_sel
  import lcdcs_pkg::*;
(
  // line context
  input  wire lcdcs_pkg::lcdcs_bias_t bias,
  input  wire logic                   phase,
  input  wire logic                   is_bp,
  input  wire logic                   sel,
  // chosen tap
  output lcdcs_pkg::lcdcs_tap_t       tap
);

  // select lines always swing between the rails; deselect levels depend on bias
  always_comb begin
    tap = TAP_GND;
    unique case (bias)
      BIAS_STATIC: begin
        // backplane top/gnd; selected segment opposite, deselected in step
        if (is_bp || !sel) tap = phase ? TAP_GND : TAP_TOP;
        else               tap = phase ? TAP_TOP : TAP_GND;
      end
      BIAS_HALF: begin
        // deselected backplane parks on the shared middle tap
        if (is_bp && !sel)     tap = TAP_ONE;
        else if (is_bp || !sel) tap = phase ? TAP_GND : TAP_TOP;
        else                   tap = phase ? TAP_TOP : TAP_GND;
      end
      BIAS_THIRD: begin
        // deselected segment tap1/tap2, deselected backplane tap2/tap1
        if (!sel)      tap = (is_bp ^ phase) ? TAP_TWO : TAP_ONE;
        else if (is_bp) tap = phase ? TAP_GND : TAP_TOP;
        else           tap = phase ? TAP_TOP : TAP_GND;
      end
      BIAS_QUARTER: begin
        // backplane gnd/top or tap1/tap3; segment top/gnd or tap1/tap2
        if (is_bp) begin
          if (sel) tap = phase ? TAP_TOP : TAP_GND;
          else     tap = phase ? TAP_THREE : TAP_ONE;
        end else begin
          if (sel) tap = phase ? TAP_GND : TAP_TOP;
          else     tap = phase ? TAP_TWO : TAP_ONE;
        end
      end
    endcase
  end

endmodule // lcdcs_tap_sel
`default_nettype wire

/* rtl/lcdcs_drive.sv */
// lcdcs_drive: backplane/segment scan sequencer with key-scan slice and avalon registers
//
// Contract
// - backplanes activated in turn per slice count
// - static mode: lines 0-3 identical waveform
// - key-scan on, except static mode: extra slice after each cycle
// - key-scan slice: backplanes at non-display levels; static bias drives them top/gnd
// - lines 4-7 unused outside eight-slice mode
// - segment takes bit k while line k active
// - bit one selects, zero deselects segment
// - key-scan: pattern low nibble, then high
// - key-scan pattern bit drives segment high/low
// - unused display bits ignored per slice mode
// - first four bytes' upper nibble reads zero
// - element on only when both at select
// - static: top/gnd, segment opposite when selected
// - half bias: deselected backplane at middle tap
// - third bias: deselect levels taps one/two
// - quarter bias backplane and segment tap pairs
// - key-scan enable is mode register bit 0
`timescale 1ns/1ps
`default_nettype none
module lcdcs_drive #(
  parameter int unsigned N_SEG       = 40,                     // segment lines
  parameter int unsigned HALF_CYCLES = lcdcs_pkg::HALF_CYCLES  // clocks per frame half
) (
  // clock and synchronous reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // avalon-mm slave
  input  wire lcdcs_pkg::lcdcs_avl_req_t avl_req,
  output logic [lcdcs_pkg::DATA_W-1:0]  avl_readdata,
  output logic                          avl_waitrequest,
  // panel drive: tap selection per line
  output lcdcs_pkg::lcdcs_tap_t         backplane_lines [lcdcs_pkg::N_BP],
  output lcdcs_pkg::lcdcs_tap_t         segment_lines   [N_SEG]
);
  import lcdcs_pkg::*;

  localparam int unsigned CNT_W = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYCLES - 1);
  localparam int unsigned IDX_W = $clog2(N_SEG);

  // software-visible state
  logic [7:0]  mode_q;                // panel_mode_reg
  logic [7:0]  pat_a_q;               // key_pattern_reg_a
  logic [7:0]  pat_b_q;               // key_pattern_reg_b
  logic [7:0]  disp_q [N_SEG];        // display memory
  // scan state
  logic [CNT_W-1:0] half_cnt_q;       // clocks within current half
  logic             phase_q;          // frame half, 0 then 1
  logic [2:0]       slice_q;          // active backplane index
  logic             key_slot_q;       // key-scan slice running
  // bus handshake
  logic             ack_q;            // one-cycle answer window

  // decoded mode fields
  logic          key_scan_enable;
  logic          disp_on;
  lcdcs_slice_t  slice_mode;
  lcdcs_bias_t   bias_mode;
  logic [2:0]    last_slice;          // highest backplane index in this mode

  assign key_scan_enable = mode_q[MODE_KEY_SCAN_BIT];
  assign disp_on         = mode_q[MODE_DISP_ON_BIT];
  assign bias_mode       = lcdcs_bias_t'(mode_q[MODE_BIAS_LSB +: 2]);

  // illegal slice codes fall back to static so the scan never runs wild
  always_comb begin
    unique case (mode_q[MODE_SLICE_LSB +: 3])
      3'h1:    slice_mode = SLICE_TWO;
      3'h2:    slice_mode = SLICE_THREE;
      3'h3:    slice_mode = SLICE_FOUR;
      3'h4:    slice_mode = SLICE_EIGHT;
      default: slice_mode = SLICE_STATIC;
    endcase
  end

  // scan length per mode
  always_comb begin
    unique case (slice_mode)
      SLICE_TWO:   last_slice = 3'h1;
      SLICE_THREE: last_slice = 3'h2;
      SLICE_FOUR:  last_slice = 3'h3;
      SLICE_EIGHT: last_slice = 3'h7;
      default:     last_slice = 3'h0;
    endcase
  end

  // key scan cannot run in static mode: no deselect level exists there
  logic key_allowed;
  assign key_allowed = key_scan_enable && (slice_mode != SLICE_STATIC);

  // ---------------------------------------------------------------- bus

  // register decode for the bus address
  logic             hit_disp;
  logic [IDX_W-1:0] disp_idx;
  logic [ADDR_W-1:0] disp_ofs;
  assign disp_ofs = avl_req.address - OFS_DISP;
  assign disp_idx = disp_ofs[IDX_W+1:2];
  assign hit_disp = (avl_req.address >= OFS_DISP) && (avl_req.address[1:0] == 2'h0) &&
                    (int'(disp_ofs[ADDR_W-1:2]) < N_SEG);

  // read mux; unmapped addresses read as zero
  logic [DATA_W-1:0] rd_d;
  always_comb begin
    rd_d = '0;
    if (hit_disp) begin
      rd_d[7:0] = disp_q[disp_idx];
    end else begin
      unique case (avl_req.address)
        OFS_MODE:   rd_d[7:0] = mode_q;
        OFS_PAT_A:  rd_d[7:0] = pat_a_q;
        OFS_PAT_B:  rd_d[7:0] = pat_b_q;
        OFS_STATUS: begin
          rd_d[STAT_SLICE_LSB +: 3] = slice_q;
          rd_d[STAT_KEY_BIT]        = key_slot_q;
          rd_d[STAT_PHASE_BIT]      = phase_q;
        end
        default:    rd_d = '0;
      endcase
    end
  end

  // each access waits exactly one cycle; the master's sampling edge commits it
  logic req;
  logic commit_wr;
  assign req       = avl_req.read || avl_req.write;
  assign commit_wr = avl_req.write && ack_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_q           <= 1'b0;
      avl_waitrequest <= 1'b1;
      avl_readdata    <= '0;
    end else if (req && !ack_q) begin
      ack_q           <= 1'b1;
      avl_waitrequest <= 1'b0;
      avl_readdata    <= rd_d;
    end else begin
      ack_q           <= 1'b0;
      avl_waitrequest <= 1'b1;
    end
  end

  // control registers
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q  <= MODE_RESET;
      pat_a_q <= 8'h00;
      pat_b_q <= 8'h00;
    end else if (commit_wr) begin
      unique case (avl_req.address)
        OFS_MODE:  mode_q  <= avl_req.writedata[7:0];
        OFS_PAT_A: pat_a_q <= avl_req.writedata[7:0];
        OFS_PAT_B: pat_b_q <= avl_req.writedata[7:0];
        default:   ;
      endcase
    end
  end

  // display memory, one flop byte per segment
  genvar gi;
  generate
    for (gi = 0; gi < N_SEG; gi++) begin : g_disp
      always_ff @(posedge clock) begin
        if (rst) begin
          disp_q[gi] <= 8'h00;
        end else if (commit_wr && hit_disp && (int'(disp_idx) == gi)) begin
          // the first bytes hold only a nibble; the rest always reads zero
          if (gi < NIBBLE_ONLY_BYTES) disp_q[gi] <= {4'h0, avl_req.writedata[3:0]};
          else                        disp_q[gi] <= avl_req.writedata[7:0];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------- scan

  // frame half timer
  logic half_end;
  assign half_end = (half_cnt_q == CNT_LAST);

  always_ff @(posedge clock) begin
    if (rst || half_end) half_cnt_q <= '0;
    else                 half_cnt_q <= half_cnt_q + 1'b1;
  end

  // each slice is two halves so every line's drive averages to zero outside the key-scan slice
  always_ff @(posedge clock) begin
    if (rst)           phase_q <= 1'b0;
    else if (half_end) phase_q <= ~phase_q;
  end

  // slice sequencer; a slice count change takes effect at the next slice boundary
  always_ff @(posedge clock) begin
    if (rst) begin
      slice_q    <= 3'h0;
      key_slot_q <= 1'b0;
    end else if (half_end && phase_q) begin
      if (key_slot_q) begin
        key_slot_q <= 1'b0;
        slice_q    <= 3'h0;
      end else if (slice_q >= last_slice) begin
        slice_q    <= 3'h0;
        key_slot_q <= key_allowed;
      end else begin
        slice_q    <= slice_q + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------- drive

  // backplane select: active line only; static drives lines 0-3 alike
  logic bp_sel [N_BP];
  logic seg_sel [N_SEG];
  lcdcs_tap_t bp_tap  [N_BP];
  lcdcs_tap_t seg_tap [N_SEG];

  generate
    for (gi = 0; gi < N_BP; gi++) begin : g_bp
      always_comb begin
        if (slice_mode == SLICE_STATIC)
          bp_sel[gi] = (gi < 4);
        else
          // lines past the scan length stay deselected; board leaves them open
          bp_sel[gi] = !key_slot_q && (int'(slice_q) == gi);
      end
      lcdcs_tap_sel u_bp_tap (
        .bias  (bias_mode),
        .phase (phase_q),
        .is_bp (1'b1),
        .sel   (bp_sel[gi]),
        .tap   (bp_tap[gi])
      );
      // display off parks the panel at ground
      always_ff @(posedge clock) begin
        if (rst || !disp_on) backplane_lines[gi] <= TAP_GND;
        else                 backplane_lines[gi] <= bp_tap[gi];
      end
    end

    for (gi = 0; gi < N_SEG; gi++) begin : g_seg
      // bit index equals the active line, so unused high bits are never fetched
      always_comb begin
        seg_sel[gi] = disp_q[gi][slice_q];
      end
      lcdcs_tap_sel u_seg_tap (
        .bias  (bias_mode),
        .phase (phase_q),
        .is_bp (1'b0),
        .sel   (seg_sel[gi]),
        .tap   (seg_tap[gi])
      );
      // key-scan patterns: reg a feeds segments 0-3, reg b 4-7; others low
      always_ff @(posedge clock) begin
        if (rst || !disp_on) begin
          segment_lines[gi] <= TAP_GND;
        end else if (key_slot_q) begin
          if (gi < 4)
            segment_lines[gi] <= pat_a_q[gi + (phase_q ? 4 : 0)] ?
                                 TAP_TOP : TAP_GND;
          else if (gi < 8)
            segment_lines[gi] <= pat_b_q[gi - 4 + (phase_q ? 4 : 0)] ?
                                 TAP_TOP : TAP_GND;
          else
            segment_lines[gi] <= TAP_GND;
        end else begin
          // full swing across an element only when both lines select
          segment_lines[gi] <= seg_tap[gi];
        end
      end
    end
  endgenerate

endmodule // lcdcs_drive
`default_nettype wire

/* verif/lcdcs_drive_assertions.sv */
// lcdcs_drive_assertions: port-level checks of the lcd drive block
`timescale 1ns/1ps
`default_nettype none
module lcdcs_drive_assertions
  import lcdcs_pkg::*;
#(
  parameter int unsigned N_SEG       = 40,
  parameter int unsigned HALF_CYCLES = 4
) (
  // clock and reset
  input wire logic                         clock,
  input wire logic                         rst,
  // register bus
  input wire lcdcs_pkg::lcdcs_avl_req_t    avl_req,
  input wire logic [lcdcs_pkg::DATA_W-1:0] avl_readdata,
  input wire logic                         avl_waitrequest,
  // panel lines
  input wire lcdcs_pkg::lcdcs_tap_t        backplane_lines [lcdcs_pkg::N_BP],
  input wire lcdcs_pkg::lcdcs_tap_t        segment_lines   [N_SEG]
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [7:0]  mode_q; // mode copy taken at each committed mode write
  logic [15:0] age_q;  // clocks since the last mode write
  wire done = !avl_waitrequest;
  wire rd_done = avl_req.read && done;
  wire wr_mode = avl_req.write && done && avl_req.address == OFS_MODE;
  // a slice count change waits for a slice boundary, so allow a margin first
  wire settled = age_q > 16'(4 * HALF_CYCLES + 4);
  wire on = settled && mode_q[MODE_DISP_ON_BIT];
  wire [1:0] bias = mode_q[MODE_BIAS_LSB +: 2];
  wire [2:0] b0 = backplane_lines[0];
  wire [2:0] s0 = segment_lines[0];
  // mode shadow
  always_ff @(posedge clock) begin
    if (rst) mode_q <= MODE_RESET;
    else if (wr_mode) mode_q <= avl_req.writedata[7:0];
  end
  // age counter saturates so a quiet mode stays settled
  always_ff @(posedge clock) begin
    if (rst) age_q <= '1;
    else if (wr_mode) age_q <= '0;
    else if (age_q != '1) age_q <= age_q + 16'h1;
  end
  AST_ANSWER: assert property ((avl_req.read || avl_req.write) && avl_waitrequest |=> done)
    else $error("no answer one clock after request");
  AST_ONE_LOW: assert property (done |=> !done)
    else $error("waitrequest low longer than one clock");
  AST_BYTE_WIDE: assert property (rd_done |-> avl_readdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  AST_NIBBLE_ZERO: assert property (rd_done && avl_req.address >= OFS_DISP &&
      avl_req.address < OFS_DISP + 10'h010 |-> avl_readdata[7:4] == 4'h0)
    else $error("upper nibble of first display bytes not zero");
  AST_MODE_BACK: assert property (rd_done && avl_req.address == OFS_MODE
      |-> avl_readdata[7:0] == mode_q)
    else $error("mode register read back wrong");
  AST_DISP_OFF: assert property (settled && !mode_q[MODE_DISP_ON_BIT]
      |-> b0 == TAP_GND && backplane_lines[7] == TAP_GND && s0 == TAP_GND)
    else $error("lines not at ground with display off");
  AST_STATIC_SAME: assert property (on && mode_q[3:1] == 3'h0 && bias == 2'h0
      |-> b0 == backplane_lines[1] && b0 == backplane_lines[2] && b0 == backplane_lines[3])
    else $error("static backplanes differ");
  AST_STATIC_TOP: assert property (on && bias == 2'h0
      |-> (b0 == TAP_TOP || b0 == TAP_GND) && (s0 == TAP_TOP || s0 == TAP_GND))
    else $error("static levels not top or ground");
  AST_HALF_SEG: assert property (on && bias == 2'h1
      |-> (s0 == TAP_TOP || s0 == TAP_GND) && b0 != TAP_THREE)
    else $error("half bias level wrong");
  AST_THIRD_TAP: assert property (on && bias == 2'h2 |-> s0 != TAP_THREE && b0 != TAP_THREE)
    else $error("third bias used tap three");
  AST_QUARTER_BP: assert property (on && bias == 2'h3 |-> b0 != TAP_TWO)
    else $error("quarter bias backplane on tap two");
endmodule // lcdcs_drive_assertions
`default_nettype wire

/* verif/lcdcs_panel_model.sv */
// lcdcs_panel_model: passive glass panel that records lit elements and key-scan patterns
`timescale 1ns/1ps
`default_nettype none
module lcdcs_panel_model
  import lcdcs_pkg::*;
#(
  parameter int unsigned N_SEG       = 8,
  parameter int unsigned HALF_CYCLES = 4
) (
  // clock and tally clear
  input wire logic                  clock,
  input wire logic                  clr,
  // drive lines from the device
  input wire lcdcs_pkg::lcdcs_tap_t backplane_lines [lcdcs_pkg::N_BP],
  input wire lcdcs_pkg::lcdcs_tap_t segment_lines   [N_SEG],
  // observations
  output logic [63:0]               lit,
  output logic [7:0]                key_lo,
  output logic [7:0]                key_hi,
  output logic [7:0]                key_slots,
  output logic                      key_bad
);
  logic       key_now;        // no backplane at a select level
  logic       key_was = 1'b0;
  logic [7:0] hi;             // segments driven high
  int         kcnt = 0;
  // key slot seen when every backplane sits at a non-display level
  always_comb begin
    key_now = 1'b1;
    for (int k = 0; k < 8; k++) begin
      if (backplane_lines[k] == TAP_TOP || backplane_lines[k] == TAP_GND) key_now = 1'b0;
    end
    for (int s = 0; s < 8; s++) hi[s] = segment_lines[s] == TAP_TOP;
  end
  // an element lights only on full swing between its two lines; the tally
  // covers every line, the bench ignores the ones a board leaves open
  always_ff @(posedge clock) begin
    if (clr) begin
      lit <= '0;
      key_slots <= '0;
      key_bad <= 1'b0;
    end else begin
      for (int k = 0; k < 8; k++) begin
        for (int s = 0; s < 8; s++) begin
          if ((backplane_lines[k] == TAP_TOP && segment_lines[s] == TAP_GND) ||
              (backplane_lines[k] == TAP_GND && segment_lines[s] == TAP_TOP))
            lit[k * 8 + s] <= 1'b1;
        end
      end
      if (key_now && !key_was) key_slots <= key_slots + 8'h1;
      for (int s = 0; s < 8; s++) begin
        if (key_now && segment_lines[s] != TAP_TOP && segment_lines[s] != TAP_GND) key_bad <= 1'b1;
      end
    end
    kcnt <= key_now ? kcnt + 1 : 0;
    key_was <= key_now;
    // sample each half in its second clock, clear of the edge
    if (key_now && kcnt == 1) key_lo <= hi;
    if (key_now && kcnt == HALF_CYCLES + 1) key_hi <= hi;
  end
endmodule // lcdcs_panel_model
`default_nettype wire

/* verif/test_lcdcs_drive.sv */
// test_lcdcs_drive: self-checking bench of the lcd drive block
`timescale 1ns/1ps
`default_nettype none
module test_lcdcs_drive;
  import lcdcs_pkg::*;
  localparam int unsigned NS = 8; // segments modelled
  localparam int unsigned HC = 4; // short frame half keeps the run brief
  localparam logic [2:0] SL_TAB [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h1};
  logic           clock = 1'b0;
  logic           rst = 1'b1;
  logic           clr = 1'b1;
  lcdcs_avl_req_t req = '0;
  logic [31:0]    rdata;
  logic [31:0]    q;
  logic           wreq;
  lcdcs_tap_t     bp [N_BP];
  lcdcs_tap_t     seg [NS];
  logic [63:0]    lit;
  logic [63:0]    exp_lit;
  logic [63:0]    mask;
  logic [7:0]     key_lo;
  logic [7:0]     key_hi;
  logic [7:0]     key_slots;
  logic           key_bad;
  logic [7:0]     disp [8];
  logic [7:0]     pa;
  logic [7:0]     pb;
  logic [7:0]     m;
  int             nbp;
  int             errors = 0;
  int             comparisons = 0;
  int             seed = 32'h84ff45b6;
  lcdcs_drive #(.N_SEG(NS), .HALF_CYCLES(HC)) i_lcdcs_drive (.clock(clock), .rst(rst),
    .avl_req(req), .avl_readdata(rdata), .avl_waitrequest(wreq), .backplane_lines(bp),
    .segment_lines(seg));
  lcdcs_panel_model #(.N_SEG(NS), .HALF_CYCLES(HC)) i_lcdcs_panel_model (.clock(clock),
    .clr(clr), .backplane_lines(bp), .segment_lines(seg), .lit(lit), .key_lo(key_lo),
    .key_hi(key_hi), .key_slots(key_slots), .key_bad(key_bad));
  // clock
  initial forever #5 clock = ~clock;
  // watchdog
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    wrap_up();
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one avalon access, held until waitrequest is sampled low
  // no local limit: only the watchdog ends a wait that never gets an answer
  task automatic bus(input logic rd, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    req <= '{read: rd, write: !rd, address: a, writedata: {24'h0, d}};
    do begin
      @(posedge clock);
    end while (wreq !== 1'b0);
    q = rdata;
    req <= '0;
    @(posedge clock);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    bus(1'b1, OFS_MODE, 8'h00);
    check(q, 64'(MODE_RESET));
    bus(1'b0, 10'h3f0, 8'hff);
    bus(1'b1, 10'h3f0, 8'h00);
    check(q, 64'h0);
    // one round per slice count; the last repeats two slices with key scan off
    for (int r = 0; r < 6; r++) begin
      for (int i = 0; i < 8; i++) begin
        disp[i] = 8'($random(seed));
        bus(1'b0, 10'(OFS_DISP + 4 * i), disp[i]);
        if (i < 4) disp[i][7:4] = 4'h0;
      end
      for (int i = 0; i < 8; i++) begin
        bus(1'b1, 10'(OFS_DISP + 4 * i), 8'h00);
        check(q, {56'h0, disp[i]});
      end
      pa = 8'($random(seed));
      pb = 8'($random(seed));
      bus(1'b0, OFS_PAT_A, pa);
      bus(1'b0, OFS_PAT_B, pb);
      m = {2'b10, (r == 0) ? 2'h0 : 2'(1 + $unsigned($random(seed)) % 3), SL_TAB[r], r != 5};
      bus(1'b0, OFS_MODE, m);
      bus(1'b1, OFS_MODE, 8'h00);
      check(q, {56'h0, m});
      repeat (12 * HC) @(posedge clock);
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
      repeat (40 * HC) @(posedge clock);
      nbp = (r == 0) ? 4 : (r == 4) ? 8 : (r == 5) ? 2 : r + 1;
      for (int k = 0; k < 8; k++) begin
        for (int s = 0; s < 8; s++) begin
          mask[k * 8 + s] = k < nbp;
          exp_lit[k * 8 + s] = (k < nbp) && disp[s][(r == 0) ? 0 : k];
        end
      end
      check(lit & mask, exp_lit);
      if (r == 0 || r == 5) check(64'(key_slots), 64'h0);
      else begin
        check(64'(key_slots != 8'h0), 64'h1);
        check({key_hi, key_lo}, {pb[7:4], pa[7:4], pb[3:0], pa[3:0]});
        check(64'(key_bad), 64'h0);
      end
      // status shows a backplane index inside the scan length, spare bits zero
      bus(1'b1, OFS_STATUS, 8'h00);
      check(64'((int'(q[2:0]) < nbp) && (q[31:5] == 27'h0)), 64'h1);
    end
    wrap_up();
  end
endmodule // test_lcdcs_drive
bind lcdcs_drive lcdcs_drive_assertions #(.N_SEG(N_SEG), .HALF_CYCLES(HALF_CYCLES))
  i_lcdcs_drive_assertions (.clock(clock), .rst(rst), .avl_req(avl_req),
  .avl_readdata(avl_readdata), .avl_waitrequest(avl_waitrequest),
  .backplane_lines(backplane_lines), .segment_lines(segment_lines));
`default_nettype wire
